// >>> rtl/plar_regs.vh
// Register offsets, field positions, reset values and timing counts.
`ifndef PLAR_REGS_VH
`define PLAR_REGS_VH

// =========================================================
// Register byte offsets
`define PLAR_OFS_CTRL 12'h000
`define PLAR_OFS_STATUS 12'h004
`define PLAR_OFS_IRQ_STAT 12'h008
`define PLAR_OFS_IRQ_EN 12'h00C
`define PLAR_OFS_IRQ_GEN 12'h010
`define PLAR_OFS_LM_REQ 12'h014
`define PLAR_OFS_LM_RESP 12'h018
`define PLAR_OFS_ACKID 12'h01C

// =========================================================
// Control register fields
`define PLAR_CTRL_ISOLATE 0
`define PLAR_CTRL_TX_ALLOW 1
`define PLAR_CTRL_RX_ALLOW 2
`define PLAR_CTRL_RESET 3'h0

// =========================================================
// Status register fields
`define PLAR_ST_HEALTHY 0
`define PLAR_ST_NOT_INIT 1
`define PLAR_ST_FLUSHING 2

// =========================================================
// Interrupt fields
`define PLAR_IRQ_LINK_UP 0
`define PLAR_IRQ_EN_RESET 1'h1

// =========================================================
// Link maintenance and ackID fields
`define PLAR_ACKID_W 5
`define PLAR_CMD_W 3
`define PLAR_LSTAT_W 5
`define PLAR_RESP_VALID 31
`define PLAR_RESP_ACKID_LSB 5
`define PLAR_ACK_IN_LSB 24
`define PLAR_ACK_OUTST_LSB 8
`define PLAR_ACK_OUT_LSB 0
`define PLAR_ACK_IN_WR 31
`define PLAR_ACK_OUT_WR 30

// =========================================================
// Timing
`define PLAR_CLK_MHZ 200
`define PLAR_ISO_HOLD_NS 50000
`define PLAR_ISO_HOLD_CYC (`PLAR_ISO_HOLD_NS * `PLAR_CLK_MHZ / 1000)
`define PLAR_PW_PERIOD_CYC 100000

`endif

// >>> rtl/plar_pw_gen.v
// Port-write notification generator with coalescing of link events.
`timescale 1ns/1ps
module plar_pw_gen #(
  parameter NPORTS = 4,
  parameter PERIOD = 100000
) (
  input wire clk_sys,
  input wire rst,
  input wire isolate,
  input wire [NPORTS-1:0] link_up_vec,
  input wire pw_ack,
  output reg pw_req
);

  // =========================================================
  // Edge detection over all ports
  reg [NPORTS-1:0] link_up_q;
  reg [31:0] period_cnt;
  wire any_rise;
  wire repeat_tick;

  assign any_rise = |(link_up_vec & ~link_up_q);
  assign repeat_tick = isolate && link_up_vec[0] && (period_cnt == 32'h0);

  always @(posedge clk_sys) begin
    if (rst) begin
      link_up_q <= {NPORTS{1'b0}};
    end else begin
      link_up_q <= link_up_vec;
    end
  end

  // =========================================================
  // Repeat timer while the local port is isolated and up
  always @(posedge clk_sys) begin
    if (rst) begin
      period_cnt <= 32'h0;
    end else if (!(isolate && link_up_vec[0]) || period_cnt == 32'h0) begin
      period_cnt <= PERIOD - 1;
    end else begin
      period_cnt <= period_cnt - 32'h1;
    end
  end

  // =========================================================
  // Request flag
  // Several ports rising together make a single request, so the host
  // is not flooded when a whole shelf powers up at once.
  always @(posedge clk_sys) begin
    if (rst) begin
      pw_req <= 1'b0;
    end else if ((isolate && any_rise) || repeat_tick) begin // RULE10 RULE11
      pw_req <= 1'b1;
    end else if (pw_ack) begin
      pw_req <= 1'b0;
    end
  end

endmodule // plar_pw_gen

// >>> rtl/plar_top.v
// Port isolation, link-up notification and ackID recovery registers.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "plar_regs.vh"

// Summary of operation
// RULE1: Setting isolation flushes every packet in ingress and egress buffers.
// RULE2: Host holds isolation at least 50 us so the flush completes.
// RULE3: While isolated only link-request and link-response symbols pass.
// RULE4: Not isolated, transmit-allow gates non-maintenance outbound packets.
// RULE5: Not isolated, receive-allow gates non-maintenance inbound packets.
// RULE6: Link-up flag sets on link initialisation only while isolated.
// RULE7: Link-up interrupt raised only while its enable is nonzero.
// RULE8: Writing the force bit raises a link-up interrupt artificially.
// RULE9: Interrupt stays while flag set; host clears flag to end it.
// RULE10: Isolated with link up, port-writes repeat to announce new parts.
// RULE11: Ports activating together yield one single port-write.
// RULE12: Healthy bit set only while the port can carry traffic.
// RULE13: Not-initialised bit reads set whenever the link is down.
// RULE14: Request write sends link request; reply lands in response register.
// RULE15: AckID register shows inbound, outbound, outstanding; outbound writable.
// RULE16: Host writes partner ackIDs at priority 2, inbound plus one.
// RULE17: Host programs switch outbound before the partner's outbound.
// RULE18: No packets until outbound matches partner's expected inbound.
// RULE19: Late-updating partner: wait timeout, request again, compare.
// RULE20: Partner without recovery registers: host zeroes switch inbound.
// RULE21: Host checks and clears error bits throughout recovery.
// RULE22: Isolated port drops fabric packets and refuses partner packets.
module plar_top #(
  parameter NPEERS = 3,
  parameter ISO_HOLD_CYC = `PLAR_ISO_HOLD_CYC,
  parameter PW_PERIOD_CYC = `PLAR_PW_PERIOD_CYC
) (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire link_init,
  input wire [NPEERS-1:0] peer_link_init,
  input wire [`PLAR_ACKID_W-1:0] ackid_inbound,
  input wire [`PLAR_ACKID_W-1:0] ackid_outbound,
  input wire [`PLAR_ACKID_W-1:0] ackid_outstanding,
  output reg ackid_in_load,
  output reg ackid_out_load,
  output reg [`PLAR_ACKID_W-1:0] ackid_load_value,
  output reg lreq_valid,
  output reg [`PLAR_CMD_W-1:0] lreq_cmd,
  input wire lresp_valid,
  input wire [`PLAR_ACKID_W-1:0] partner_next_ackid,
  input wire [`PLAR_LSTAT_W-1:0] lresp_status,
  output reg flush_ingress,
  output reg flush_egress,
  output reg ctrl_sym_only,
  output reg tx_pkt_allow,
  output reg rx_pkt_allow,
  output reg tx_maint_allow,
  output reg rx_maint_allow,
  output reg irq_link_up,
  output reg pw_req,
  input wire pw_ack
);

  // =========================================================
  // Address decode
  function is_reg;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      is_reg = (addr == ofs);
    end
  endfunction

  wire setup_ph;
  wire wr_fire;
  wire rd_hit;
  assign setup_ph = psel && !penable;
  assign wr_fire = psel && penable && pready && pwrite;
  assign rd_hit = is_reg(paddr, `PLAR_OFS_CTRL) ||
                  is_reg(paddr, `PLAR_OFS_STATUS) ||
                  is_reg(paddr, `PLAR_OFS_IRQ_STAT) ||
                  is_reg(paddr, `PLAR_OFS_IRQ_EN) ||
                  is_reg(paddr, `PLAR_OFS_IRQ_GEN) ||
                  is_reg(paddr, `PLAR_OFS_LM_REQ) ||
                  is_reg(paddr, `PLAR_OFS_LM_RESP) ||
                  is_reg(paddr, `PLAR_OFS_ACKID);

  // =========================================================
  // Write strobes shared by several registers
  wire wr_lm_req;
  wire wr_ackid;
  assign wr_lm_req = wr_fire && is_reg(paddr, `PLAR_OFS_LM_REQ);
  assign wr_ackid = wr_fire && is_reg(paddr, `PLAR_OFS_ACKID);

  // =========================================================
  // Software state
  reg [2:0] ctrl;
  reg link_up_flag;
  reg link_up_en;
  reg link_init_q;
  reg resp_valid;
  reg [`PLAR_ACKID_W-1:0] resp_ackid;
  reg [`PLAR_LSTAT_W-1:0] resp_status;
  reg [31:0] hold_cnt;
  reg flushing;
  reg [31:0] next_rdata;
  wire isolate;
  wire tx_allow;
  wire rx_allow;
  wire iso_rise;
  wire link_rise;
  wire force_wr;
  wire clr_wr;
  wire pw_req_int;

  assign isolate = ctrl[`PLAR_CTRL_ISOLATE];
  assign tx_allow = ctrl[`PLAR_CTRL_TX_ALLOW];
  assign rx_allow = ctrl[`PLAR_CTRL_RX_ALLOW];
  assign iso_rise = wr_fire && is_reg(paddr, `PLAR_OFS_CTRL) &&
                    pwdata[`PLAR_CTRL_ISOLATE] && !isolate;
  assign link_rise = link_init && !link_init_q;
  assign force_wr = wr_fire && is_reg(paddr, `PLAR_OFS_IRQ_GEN) &&
                    pwdata[`PLAR_IRQ_LINK_UP];
  assign clr_wr = wr_fire && is_reg(paddr, `PLAR_OFS_IRQ_STAT) &&
                  pwdata[`PLAR_IRQ_LINK_UP];

  // =========================================================
  // APB slave: no wait state, answer registered
  // The read value is latched in the setup cycle so prdata comes
  // straight from a flop without adding any wait state.
  always @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (setup_ph) begin
      pready <= 1'b1;
      pslverr <= !rd_hit;
      prdata <= (pwrite || !rd_hit) ? 32'h0 : next_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Unmapped offsets read as zero and answer with an error.
  always @* begin
    next_rdata = 32'h0;
    case (paddr)
      `PLAR_OFS_CTRL: begin
        next_rdata[2:0] = ctrl;
      end
      `PLAR_OFS_STATUS: begin
        next_rdata[`PLAR_ST_HEALTHY] = link_init && !isolate && !flushing; // RULE12
        next_rdata[`PLAR_ST_NOT_INIT] = !link_init; // RULE13
        next_rdata[`PLAR_ST_FLUSHING] = flushing;
      end
      `PLAR_OFS_IRQ_STAT: begin
        next_rdata[`PLAR_IRQ_LINK_UP] = link_up_flag;
      end
      `PLAR_OFS_IRQ_EN: begin
        next_rdata[`PLAR_IRQ_LINK_UP] = link_up_en;
      end
      `PLAR_OFS_LM_REQ: begin
        next_rdata[`PLAR_CMD_W-1:0] = lreq_cmd;
      end
      `PLAR_OFS_LM_RESP: begin
        next_rdata[`PLAR_RESP_VALID] = resp_valid;
        next_rdata[`PLAR_RESP_ACKID_LSB+`PLAR_ACKID_W-1:
                   `PLAR_RESP_ACKID_LSB] = resp_ackid;
        next_rdata[`PLAR_LSTAT_W-1:0] = resp_status;
      end
      `PLAR_OFS_ACKID: begin
        next_rdata[`PLAR_ACK_IN_LSB+`PLAR_ACKID_W-1:
                   `PLAR_ACK_IN_LSB] = ackid_inbound; // RULE15
        next_rdata[`PLAR_ACK_OUTST_LSB+`PLAR_ACKID_W-1:
                   `PLAR_ACK_OUTST_LSB] = ackid_outstanding; // RULE15
        next_rdata[`PLAR_ACK_OUT_LSB+`PLAR_ACKID_W-1:
                   `PLAR_ACK_OUT_LSB] = ackid_outbound; // RULE15
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  // =========================================================
  // Control and enable registers
  // Reserved control bits read back as zero and ignore writes.
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= `PLAR_CTRL_RESET;
      link_up_en <= `PLAR_IRQ_EN_RESET;
    end else if (wr_fire) begin
      if (is_reg(paddr, `PLAR_OFS_CTRL)) begin
        ctrl <= pwdata[2:0];
      end
      if (is_reg(paddr, `PLAR_OFS_IRQ_EN)) begin
        link_up_en <= pwdata[`PLAR_IRQ_LINK_UP];
      end
    end
  end

  // =========================================================
  // Flush and isolation hold timer
  // The flush runs for the full hold time even if software lifts
  // isolation early; dropping it half way could leave stale packets.
  always @(posedge clk_sys) begin
    if (rst) begin
      hold_cnt <= 32'h0;
      flushing <= 1'b0;
      flush_ingress <= 1'b0;
      flush_egress <= 1'b0;
    end else begin
      if (iso_rise) begin
        hold_cnt <= ISO_HOLD_CYC - 1;
        flushing <= 1'b1;
      end else if (hold_cnt != 32'h0) begin
        hold_cnt <= hold_cnt - 32'h1;
      end else begin
        flushing <= 1'b0;
      end
      flush_ingress <= iso_rise || flushing; // RULE1 RULE2
      flush_egress <= iso_rise || flushing; // RULE1 RULE2
    end
  end

  // =========================================================
  // Packet gating
  // Maintenance traffic is held off during the flush as well, so nothing
  // new lands in a buffer that is being emptied.
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_sym_only <= 1'b0;
      tx_pkt_allow <= 1'b0;
      rx_pkt_allow <= 1'b0;
      tx_maint_allow <= 1'b0;
      rx_maint_allow <= 1'b0;
    end else begin
      ctrl_sym_only <= isolate; // RULE3
      tx_pkt_allow <= !isolate && !flushing && tx_allow; // RULE4 RULE22
      rx_pkt_allow <= !isolate && !flushing && rx_allow; // RULE5 RULE22
      tx_maint_allow <= !isolate && !flushing; // RULE3 RULE22
      rx_maint_allow <= !isolate && !flushing; // RULE3 RULE22
    end
  end

  // =========================================================
  // Link-up flag and interrupt
  // Masking hides the interrupt but keeps the flag, so a poll still sees
  // an insertion that happened while the line was masked.
  always @(posedge clk_sys) begin
    if (rst) begin
      link_init_q <= 1'b0;
      link_up_flag <= 1'b0;
      irq_link_up <= 1'b0;
    end else begin
      link_init_q <= link_init;
      // A new event in the clearing cycle wins over the clear.
      if ((link_rise && isolate) || force_wr) begin // RULE6 RULE8
        link_up_flag <= 1'b1;
      end else if (clr_wr) begin // RULE9
        link_up_flag <= 1'b0;
      end
      irq_link_up <= link_up_flag && link_up_en; // RULE7 RULE9
    end
  end

  // =========================================================
  // Link maintenance request and response
  always @(posedge clk_sys) begin
    if (rst) begin
      lreq_valid <= 1'b0;
      lreq_cmd <= {`PLAR_CMD_W{1'b0}};
      resp_valid <= 1'b0;
      resp_ackid <= {`PLAR_ACKID_W{1'b0}};
      resp_status <= {`PLAR_LSTAT_W{1'b0}};
    end else begin
      lreq_valid <= wr_lm_req; // RULE14
      if (wr_lm_req) begin
        lreq_cmd <= pwdata[`PLAR_CMD_W-1:0];
      end
      // A new request drops the old answer unless a reply lands in the same cycle;
      // that stale reply wins and still reads as valid after the new request.
      if (lresp_valid) begin // RULE14
        resp_valid <= 1'b1;
        resp_ackid <= partner_next_ackid;
        resp_status <= lresp_status;
      end else if (wr_lm_req) begin
        resp_valid <= 1'b0;
      end
    end
  end

  // =========================================================
  // AckID reprogramming
  // Inbound is loadable too so that a partner without recovery
  // registers can be met by zeroing the local inbound value.
  always @(posedge clk_sys) begin
    if (rst) begin
      ackid_in_load <= 1'b0;
      ackid_out_load <= 1'b0;
      ackid_load_value <= {`PLAR_ACKID_W{1'b0}};
    end else begin
      ackid_in_load <= wr_ackid &&
                       pwdata[`PLAR_ACK_IN_WR]; // RULE20
      ackid_out_load <= wr_ackid &&
                        pwdata[`PLAR_ACK_OUT_WR]; // RULE15 RULE18
      if (wr_ackid) begin
        ackid_load_value <= pwdata[`PLAR_ACKID_W-1:0];
      end
    end
  end

  // =========================================================
  // Port-write notification
  plar_pw_gen #(
    .NPORTS(NPEERS + 1),
    .PERIOD(PW_PERIOD_CYC)
  ) u_pw (
    .clk_sys(clk_sys),
    .rst(rst),
    .isolate(isolate),
    .link_up_vec({peer_link_init, link_init}),
    .pw_ack(pw_ack),
    .pw_req(pw_req_int)
  );

  // The registered copy drops in the acknowledge cycle itself, so the
  // request never outlives its acknowledge by a cycle.
  always @(posedge clk_sys) begin
    if (rst) begin
      pw_req <= 1'b0;
    end else begin
      pw_req <= pw_req_int && !pw_ack; // RULE10
    end
  end

endmodule // plar_top

// >>> dv/plar_asserts.sv
// Concurrent checks on the isolation, interrupt and link maintenance ports.
`timescale 1ns/1ps
`include "plar_regs.vh"
module plar_asserts (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire link_init,
  input wire lreq_valid,
  input wire [`PLAR_CMD_W-1:0] lreq_cmd,
  input wire ackid_out_load,
  input wire [`PLAR_ACKID_W-1:0] ackid_load_value,
  input wire flush_ingress,
  input wire flush_egress,
  input wire ctrl_sym_only,
  input wire tx_pkt_allow,
  input wire rx_pkt_allow,
  input wire irq_link_up
);
  // ====
  // Helper logic
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire wr = psel & penable & pready & pwrite;
  wire rd = psel & penable & pready & !pwrite;
  wire wr_ctrl = wr & (paddr == `PLAR_OFS_CTRL);
  wire wr_en = wr & (paddr == `PLAR_OFS_IRQ_EN);
  wire wr_gen = wr & (paddr == `PLAR_OFS_IRQ_GEN);
  wire wr_clr = wr_en | (wr & (paddr == `PLAR_OFS_IRQ_STAT));
  wire rd_st = rd & (paddr == `PLAR_OFS_STATUS);
  // Mirror of the enable, so a forced interrupt is only expected when unmasked.
  reg en_q;
  always @(posedge clk_sys) begin
    if (rst)
      en_q <= 1'b1;
    else if (wr_en)
      en_q <= pwdata[0];
  end
  // ====
  // Assertions
  chk_flush_start: assert property (wr_ctrl && pwdata[0] && !ctrl_sym_only
    |=> flush_ingress && flush_egress) else $error("flush not started");
  chk_iso_gate: assert property (ctrl_sym_only && $past(ctrl_sym_only)
    |-> !tx_pkt_allow && !rx_pkt_allow) else $error("packets while isolated");
  chk_tx_allow: assert property (wr_ctrl && !pwdata[0] && !ctrl_sym_only
    && !flush_egress |=> ##1 tx_pkt_allow == $past(pwdata[1], 2))
    else $error("tx allow wrong");
  chk_rx_allow: assert property (wr_ctrl && !pwdata[0] && !ctrl_sym_only
    && !flush_ingress |=> ##1 rx_pkt_allow == $past(pwdata[2], 2))
    else $error("rx allow wrong");
  chk_irq_mask: assert property (wr_en && !pwdata[0]
    |=> ##1 !irq_link_up) else $error("masked irq seen");
  chk_force_irq: assert property (wr_gen && pwdata[0] && en_q
    |=> ##1 irq_link_up) else $error("forced irq missing");
  chk_irq_hold: assert property (irq_link_up && !wr_clr && !$past(wr_clr)
    |=> irq_link_up) else $error("irq dropped");
  chk_healthy_bit: assert property (rd_st && prdata[0]
    |-> link_init && !ctrl_sym_only) else $error("healthy wrong");
  chk_not_init: assert property (rd_st && $past(link_init, 3) == link_init
    && $past(link_init) == link_init |-> prdata[1] == !link_init)
    else $error("not init wrong");
  chk_lreq_pulse: assert property (wr && paddr == `PLAR_OFS_LM_REQ
    |=> lreq_valid && lreq_cmd == $past(pwdata[2:0]) ##1 !lreq_valid)
    else $error("link request wrong");
  chk_ackid_load: assert property (wr && paddr == `PLAR_OFS_ACKID
    && pwdata[30] |=> ackid_out_load
    && ackid_load_value == $past(pwdata[4:0])) else $error("load wrong");
  cov_isolate: cover property (wr_ctrl && pwdata[0] ##1 flush_ingress);
  cov_force: cover property (wr_gen ##2 irq_link_up);
  cov_lreq: cover property (lreq_valid);
endmodule // plar_asserts
bind plar_top plar_asserts u_asserts (.*);

// >>> dv/plar_link_model.sv
// Link layer and partner model: ackID state and link responses.
`timescale 1ns/1ps
module plar_link_model #(
  parameter DLY = 6,
  parameter [4:0] PNXT = 5'h0B,
  parameter [4:0] LST = 5'h10
) (
  input wire clk_sys,
  input wire rst,
  input wire lreq_valid,
  input wire ackid_in_load,
  input wire ackid_out_load,
  input wire [4:0] ackid_load_value,
  output reg lresp_valid,
  output wire [4:0] partner_next_ackid,
  output wire [4:0] lresp_status,
  output reg [4:0] ackid_inbound,
  output reg [4:0] ackid_outbound,
  output wire [4:0] ackid_outstanding
);
  integer cnt;
  // Reply fields are scrambled outside the valid pulse to expose late reads.
  assign partner_next_ackid = lresp_valid ? PNXT : ~PNXT;
  assign lresp_status = lresp_valid ? LST : ~LST;
  assign ackid_outstanding = 5'h03;
  always @(posedge clk_sys) begin
    lresp_valid <= 1'b0;
    if (rst) begin
      cnt <= 0;
      ackid_inbound <= 5'h07;
      ackid_outbound <= 5'h01;
    end else begin
      if (lreq_valid)
        cnt <= DLY;
      else if (cnt > 0)
        cnt <= cnt - 1;
      if (cnt == 1)
        lresp_valid <= 1'b1;
      if (ackid_out_load)
        ackid_outbound <= ackid_load_value;
      if (ackid_in_load)
        ackid_inbound <= ackid_load_value;
    end
  end
endmodule // plar_link_model

// >>> dv/plar_top_tb.sv
// Register level testbench for port isolation and ackID recovery.
`timescale 1ns/1ps
`include "plar_regs.vh"
module plar_top_tb;
  localparam ISO = 8;
  localparam PWP = 32;
  localparam [4:0] PNXT = 5'h0B;
  localparam [31:0] RESP = 32'h8000_0170;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pw_ack = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg link_init = 1'b0;
  reg [2:0] peer_link_init = 3'h0;
  wire [31:0] prdata;
  wire pready, pslverr, ackid_in_load, ackid_out_load, lreq_valid;
  wire lresp_valid, flush_ingress, flush_egress, ctrl_sym_only;
  wire tx_pkt_allow, rx_pkt_allow, tx_maint_allow, rx_maint_allow;
  wire irq_link_up, pw_req;
  wire [4:0] ackid_inbound, ackid_outbound, ackid_outstanding;
  wire [4:0] ackid_load_value, partner_next_ackid, lresp_status;
  wire [2:0] lreq_cmd;
  integer num_errors = 0;
  integer checks = 0;
  integer n;
  reg [31:0] rv;
  reg err;
  plar_top #(.NPEERS(3), .ISO_HOLD_CYC(ISO), .PW_PERIOD_CYC(PWP)) dut (.*);
  plar_link_model #(.DLY(6), .PNXT(PNXT)) partner (.*);
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ====
  // Tasks
  task stop_test;
    begin
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task give_up;
    begin
      num_errors = num_errors + 1;
      stop_test;
    end
  endtask
  task chk(input [8*10:1] what, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clk_sys);
  endtask
  // An idle edge follows each transfer so psel is never driven twice at once.
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      tick(1);
      penable <= 1'b1;
      k = 0;
      tick(1);
      while (pready !== 1'b1 && k < 16) begin
        tick(1);
        k = k + 1;
      end
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tick(1);
      if (k == 16)
        give_up;
    end
  endtask
  task wait_pw(input integer lim);
    integer k;
    begin
      k = 0;
      while (pw_req !== 1'b1 && k < lim) begin
        tick(1);
        k = k + 1;
      end
      if (k == lim)
        give_up;
    end
  endtask
  task ack_pw;
    begin
      pw_ack <= 1'b1;
      tick(1);
      pw_ack <= 1'b0;
      tick(1);
    end
  endtask
  task lm_req;
    integer k;
    begin
      apb(1, `PLAR_OFS_LM_REQ, 32'h4);
      k = 0;
      rv = 0;
      while (rv[31] !== 1'b1 && k < 8) begin
        apb(0, `PLAR_OFS_LM_RESP, 0);
        k = k + 1;
      end
      chk("lm_resp", RESP, rv);
      if (rv[31] !== 1'b1)
        give_up;
    end
  endtask
  // ====
  // Sequence
  initial begin
    tick(3);
    rst <= 1'b0;
    tick(1);
    apb(0, `PLAR_OFS_CTRL, 0);
    chk("ctrl", 0, rv);
    apb(0, `PLAR_OFS_IRQ_EN, 0);
    chk("irq_en", 1, rv);
    apb(1, 12'h040, 32'h7);
    chk("slverr", 1, err);
    apb(0, 12'h040, 0);
    chk("unmapped", 0, rv);
    apb(0, `PLAR_OFS_STATUS, 0);
    chk("status", 32'h2, rv);
    link_init <= 1'b1;
    tick(4);
    apb(0, `PLAR_OFS_STATUS, 0);
    chk("status", 32'h1, rv);
    apb(0, `PLAR_OFS_IRQ_STAT, 0);
    chk("irq_stat", 0, rv);
    for (n = 0; n < 4; n = n + 1) begin
      apb(1, `PLAR_OFS_CTRL, n << 1);
      tick(2);
      chk("allow", n, {rx_pkt_allow, tx_pkt_allow});
      chk("maint", 3, {tx_maint_allow, rx_maint_allow});
    end
    link_init <= 1'b0;
    tick(2);
    apb(1, `PLAR_OFS_CTRL, 32'h7);
    chk("flush", 3, {flush_ingress, flush_egress});
    tick(1);
    chk("gating", 4, {ctrl_sym_only, tx_pkt_allow, rx_pkt_allow});
    chk("maint", 0, {tx_maint_allow, rx_maint_allow});
    apb(0, `PLAR_OFS_STATUS, 0);
    chk("status", 32'h6, rv);
    tick(ISO + 4);
    chk("flush", 0, {flush_ingress, flush_egress});
    link_init <= 1'b1;
    peer_link_init <= 3'h7;
    wait_pw(8);
    apb(0, `PLAR_OFS_IRQ_STAT, 0);
    chk("irq_stat", 1, rv);
    chk("irq", 1, irq_link_up);
    ack_pw;
    tick(3);
    chk("pw_req", 0, pw_req);
    wait_pw(PWP + 8);
    ack_pw;
    apb(1, `PLAR_OFS_IRQ_EN, 0);
    tick(1);
    chk("irq", 0, irq_link_up);
    apb(1, `PLAR_OFS_IRQ_STAT, 1);
    apb(1, `PLAR_OFS_IRQ_EN, 1);
    tick(1);
    chk("irq", 0, irq_link_up);
    apb(1, `PLAR_OFS_IRQ_GEN, 1);
    tick(1);
    chk("irq", 1, irq_link_up);
    apb(1, `PLAR_OFS_IRQ_STAT, 1);
    tick(1);
    chk("irq", 0, irq_link_up);
    apb(0, `PLAR_OFS_ACKID, 0);
    chk("ackid", 32'h0700_0301, rv);
    apb(0, `PLAR_OFS_STATUS, 0);
    chk("status", 32'h0, rv);
    lm_req;
    apb(1, `PLAR_OFS_ACKID, 32'h4000_0000 | PNXT);
    apb(0, `PLAR_OFS_ACKID, 0);
    chk("ackid", 32'h0700_0300 | PNXT, rv);
    lm_req;
    chk("resync", rv[9:5], ackid_outbound);
    apb(1, `PLAR_OFS_ACKID, 32'h8000_0000);
    apb(0, `PLAR_OFS_ACKID, 0);
    chk("ackid", 32'h0000_0300 | PNXT, rv);
    apb(1, `PLAR_OFS_CTRL, 32'h6);
    tick(3);
    chk("allow", 3, {rx_pkt_allow, tx_pkt_allow});
    chk("maint", 3, {tx_maint_allow, rx_maint_allow});
    apb(0, `PLAR_OFS_STATUS, 0);
    chk("status", 32'h1, rv);
    stop_test;
  end
endmodule // plar_top_tb
